// ---- rtl/ods_pkg.sv ----
package ods_pkg;

  // field widths
  localparam int WAVE_W   = 3;   // waveform code width
  localparam int OP_W     = 4;   // command code width
  localparam int AMP_W    = 14;  // amplitude in mV, peak to peak
  localparam int BIAS_W   = 16;  // signed offset level in mV
  localparam int RATIO_W  = 10;  // on fraction in 0.1 % steps
  localparam int NUM_W    = 32;  // numeric parameter width
  localparam int MANT_W   = 16;  // reply mantissa width
  localparam int EXP_W    = 8;   // reply exponent width
  localparam int POINT_W  = 2;   // reply digits after the point
  localparam int NUM_WAVES = 6;  // number of waveform types

  // limits and rounding figures
  localparam logic [NUM_W-1:0] BIAS_LIMIT_MV  = 32'h0000_13A1;  // 5025 mV for |offset| + amplitude/2
  localparam logic [NUM_W-1:0] UV_PER_MV      = 32'h0000_03E8;  // 1000 uV per mV
  localparam logic [NUM_W-1:0] HALF_MV_UV     = 32'h0000_01F4;  // 500 uV, half a mV
  localparam logic [NUM_W-1:0] THREE_DIG_MV   = 32'h0000_03E8;  // 1000 mV, where 3 digits mean a 10 mV step
  localparam logic [NUM_W-1:0] TEN_MV         = 32'h0000_000A;  // 10 mV step above 1 V
  localparam logic [NUM_W-1:0] HALF_TEN_MV    = 32'h0000_0005;  // half of the 10 mV step
  localparam logic [NUM_W-1:0] ON_THRESH      = 32'h0000_01F4;  // 0.5 in thousandths rounds to 1
  localparam logic [NUM_W-1:0] RATIO_DIV      = 32'h0000_000A;  // hundredths of % per 0.1 % step
  localparam logic [NUM_W-1:0] RATIO_HALF     = 32'h0000_0005;  // half of a 0.1 % step

  // reset values
  localparam logic [RATIO_W-1:0]       RATIO_RST = 10'h1F4;  // 50.0 % for every waveform
  localparam logic signed [BIAS_W-1:0] BIAS_RST  = 16'h0000; // offset level 0 mV

  // reply encodings
  localparam logic signed [MANT_W-1:0] RATIO_NONE = 16'hFFF6;  // -1.0 in tenths
  localparam logic signed [EXP_W-1:0]  EXP_MILLI  = 8'hFD;     // 10^-3
  localparam logic signed [EXP_W-1:0]  EXP_UNIT   = 8'h00;     // 10^0
  localparam logic [POINT_W-1:0]       PT_NONE    = 2'h0;
  localparam logic [POINT_W-1:0]       PT_TENTHS  = 2'h1;
  localparam logic [POINT_W-1:0]       PT_HUNDRED = 2'h2;

  // waveform types; the long and the short sine keyword both select sinusoid
  typedef enum logic [WAVE_W-1:0] {
    WAVE_SINUSOID    = 3'h0,
    WAVE_TRIANGLE    = 3'h1,
    WAVE_RECTANGULAR = 3'h2,
    WAVE_NARROW_RECT = 3'h3,
    WAVE_RAMP        = 3'h4,
    WAVE_DC          = 3'h5
  } ods_wave_t;

  // decoded host commands
  typedef enum logic [OP_W-1:0] {
    OP_NONE             = 4'h0,
    OP_BIAS_ENABLE_SET  = 4'h1,
    OP_BIAS_ENABLE_QRY  = 4'h2,
    OP_BIAS_LEVEL_SET   = 4'h3,
    OP_BIAS_LEVEL_QRY   = 4'h4,
    OP_FRAC_ENABLE_SET  = 4'h5,
    OP_FRAC_ENABLE_QRY  = 4'h6,
    OP_FRAC_LEVEL_SET   = 4'h7,
    OP_FRAC_LEVEL_QRY   = 4'h8,
    OP_EMIT_SET         = 4'h9,
    OP_EMIT_QRY         = 4'hA,
    OP_WAVE_QRY         = 4'hB
  } ods_op_t;

  // reply kinds
  typedef enum logic [1:0] {
    RSP_NUMBER   = 2'h0,
    RSP_OVERFLOW = 2'h1,
    RSP_WAVE     = 2'h2
  } ods_kind_t;

  // one parsed command; num is uV, thousandths or hundredths of % by command
  typedef struct packed {
    logic                    valid;
    ods_op_t                 op;
    logic                    isWord;
    logic                    wordOn;
    logic signed [NUM_W-1:0] num;
  } ods_cmd_t;

  // one reply: value = mant / 10^point * 10^exp
  typedef struct packed {
    logic                     valid;
    ods_kind_t                kind;
    logic signed [MANT_W-1:0] mant;
    logic [POINT_W-1:0]       point;
    logic signed [EXP_W-1:0]  exp;
    ods_wave_t                wave;
  } ods_rsp_t;

endpackage : ods_pkg

// ---- rtl/ods_ratio_mem.sv ----
`timescale 1ns/1ns
module ods_ratio_mem (
  // clock and reset
  input  wire logic                         core_clk,
  input  wire logic                         rst,
  // write port
  input  wire logic                         writeEn,
  input  wire logic [ods_pkg::WAVE_W-1:0]   writeAddr,
  input  wire logic [ods_pkg::RATIO_W-1:0]  writeData,
  // read port, data one cycle after the address
  input  wire logic [ods_pkg::WAVE_W-1:0]   readAddr,
  output      logic [ods_pkg::RATIO_W-1:0]  readData
);
  import ods_pkg::*;

  logic [RATIO_W-1:0] store [NUM_WAVES];  // one ratio per waveform

  // storage; every entry restarts at the default ratio
  genvar gi;
  generate
    for (gi = 0; gi < NUM_WAVES; gi++) begin : g_entry
      always_ff @(posedge core_clk) begin
        if (rst) begin
          store[gi] <= RATIO_RST;
        end else if (writeEn && (writeAddr == WAVE_W'(gi))) begin
          store[gi] <= writeData;
        end
      end
    end
  endgenerate

  // registered read; a write to the read address passes through so no stale value shows
  always_ff @(posedge core_clk) begin
    if (rst) begin
      readData <= RATIO_RST;
    end else if (writeEn && (writeAddr == readAddr)) begin
      readData <= writeData;
    end else if (readAddr < NUM_WAVES[WAVE_W-1:0]) begin
      readData <= store[readAddr];
    end else begin
      readData <= RATIO_RST;  // unused codes read as default
    end
  end

endmodule : ods_ratio_mem

// ---- rtl/ods_settings.sv ----
`timescale 1ns/1ns
module ods_settings (
  // clock and reset
  input  wire logic                               core_clk,
  input  wire logic                               rst,
  // command in, reply out
  input  wire ods_pkg::ods_cmd_t                  cmdIn,
  output      logic                               cmdReady,
  output      ods_pkg::ods_rsp_t                  rspOut,
  // context from neighbouring blocks
  input  wire ods_pkg::ods_wave_t                 waveSel,
  input  wire logic [ods_pkg::AMP_W-1:0]          ampMv,
  input  wire logic [ods_pkg::RATIO_W-1:0]        ratioMin,
  input  wire logic [ods_pkg::RATIO_W-1:0]        ratioMax,
  // settings
  output      logic                               biasEnable,
  output      logic signed [ods_pkg::BIAS_W-1:0]  biasLevel,
  output      logic                               onFractionEnable,
  output      logic [ods_pkg::RATIO_W-1:0]        onFractionLevel,
  output      logic                               emitEnable,
  output      logic                               dcForceOff,
  // execution error
  input  wire logic                               execErrClear,
  output      logic                               execErrFlag,
  output      logic                               execErrPulse
);
  import ods_pkg::*;

  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,  // waiting for a command
    ST_EXEC = 1'b1   // latched command is carried out
  } ods_state_t;

  ods_state_t               stateReg;        // command sequencer
  ods_state_t               stateNext;
  ods_cmd_t                 cmdReg;          // command under execution
  ods_wave_t                waveReg;         // waveform seen last cycle
  logic                     waveChange;      // waveform switched this cycle
  logic [RATIO_W-1:0]       memRatio;        // stored ratio of waveReg
  logic                     memWe;           // ratio store write
  logic [RATIO_W-1:0]       memWdata;
  logic                     biasEnableNext;
  logic signed [BIAS_W-1:0] biasLevelNext;
  logic                     fracEnableNext;
  logic                     emitEnableNext;
  logic                     errNow;          // this execution is an error
  ods_rsp_t                 rspNext;
  logic                     switchOn;        // decoded on/off parameter
  logic                     isDc;
  logic                     canRatio;
  logic [NUM_W-1:0]         lim;             // offset magnitude allowed now
  logic [NUM_W-1:0]         mag;             // working magnitude
  logic [NUM_W-1:0]         absUv;           // offset request magnitude in uV
  logic [NUM_W-1:0]         halfAmp;

  // on/off decode shared by every switch command
  function automatic logic onOffValue(input ods_cmd_t c);
    logic [NUM_W-1:0] a;
    a = c.num[NUM_W-1] ? NUM_W'(-c.num) : NUM_W'(c.num);
    if (c.isWord) begin
      onOffValue = c.wordOn;
    end else begin
      onOffValue = (a >= ON_THRESH);
    end
  endfunction : onOffValue

  // waveforms on which the ratio function may be on
  function automatic logic waveCanRatio(input ods_wave_t w);
    waveCanRatio = (w == WAVE_RECTANGULAR) || (w == WAVE_NARROW_RECT) || (w == WAVE_RAMP);
  endfunction : waveCanRatio

  // plain numeric reply
  function automatic ods_rsp_t numRsp(input logic signed [MANT_W-1:0] m, input logic [POINT_W-1:0] p,
                                      input logic signed [EXP_W-1:0] e);
    numRsp       = '0;
    numRsp.valid = 1'b1;
    numRsp.kind  = RSP_NUMBER;
    numRsp.mant  = m;
    numRsp.point = p;
    numRsp.exp   = e;
  endfunction : numRsp

  // offset reply: mV below 1 V, volts with two decimals above
  function automatic ods_rsp_t biasRsp(input logic signed [BIAS_W-1:0] lvl);
    logic [BIAS_W-1:0]        a;
    logic signed [MANT_W-1:0] m;
    a = lvl[BIAS_W-1] ? BIAS_W'(-lvl) : BIAS_W'(lvl);
    if (a >= THREE_DIG_MV[BIAS_W-1:0]) begin
      m = MANT_W'(a / TEN_MV[BIAS_W-1:0]);
      biasRsp = numRsp(lvl[BIAS_W-1] ? -m : m, PT_HUNDRED, EXP_UNIT);
    end else if (a == '0) begin
      biasRsp = numRsp('0, PT_NONE, EXP_UNIT);
    end else begin
      m = MANT_W'(a);
      biasRsp = numRsp(lvl[BIAS_W-1] ? -m : m, PT_NONE, EXP_MILLI);
    end
  endfunction : biasRsp

  // waveform context
  assign waveChange = (waveSel != waveReg);
  assign isDc       = (waveReg == WAVE_DC);
  assign canRatio   = waveCanRatio(waveReg);
  assign switchOn   = onOffValue(cmdReg);
  assign halfAmp    = NUM_W'((ampMv + AMP_W'(1)) >> 1);  // rounds up so the sum never passes the limit
  assign lim        = (halfAmp >= BIAS_LIMIT_MV) ? '0 : (BIAS_LIMIT_MV - halfAmp);

  // a command is only taken while the stored ratio matches the waveform
  assign cmdReady = (stateReg == ST_IDLE) && !waveChange;

  // one execution cycle after every accepted command
  always_comb begin
    stateNext = stateReg;
    case (stateReg)
      ST_IDLE: begin
        if (cmdIn.valid && cmdReady) begin
          stateNext = ST_EXEC;
        end
      end
      ST_EXEC: stateNext = ST_IDLE;
      default: stateNext = ST_IDLE;
    endcase
  end

  // command execution: next settings, reply and error
  always_comb begin
    biasEnableNext = biasEnable;
    biasLevelNext  = biasLevel;
    fracEnableNext = onFractionEnable;
    emitEnableNext = emitEnable;
    memWe          = 1'b0;
    memWdata       = memRatio;
    errNow         = 1'b0;
    rspNext        = '0;
    mag            = '0;
    absUv          = '0;
    if (stateReg == ST_EXEC) begin
      case (cmdReg.op)
        OP_BIAS_ENABLE_SET: begin
          if (switchOn && isDc) begin
            errNow = 1'b1;
          end else begin
            biasEnableNext = switchOn;
          end
        end
        OP_BIAS_ENABLE_QRY: begin
          errNow  = isDc;
          rspNext = numRsp({{(MANT_W-1){1'b0}}, biasEnable && !isDc}, PT_NONE, EXP_UNIT);
        end
        OP_BIAS_LEVEL_SET: begin
          if (isDc) begin
            errNow = 1'b1;
          end else if (!biasEnable) begin
            errNow = 1'b1;
          end else begin
            absUv = cmdReg.num[NUM_W-1] ? NUM_W'(-cmdReg.num) : NUM_W'(cmdReg.num);
            mag   = (absUv + HALF_MV_UV) / UV_PER_MV;
            if (mag >= THREE_DIG_MV) begin
              // round once from uV; rounding the mV result again would carry a lower digit up
              mag = ((absUv + HALF_MV_UV * TEN_MV) / (UV_PER_MV * TEN_MV)) * TEN_MV;
            end
            if (mag > lim) begin
              errNow = 1'b1;
              mag    = (lim >= THREE_DIG_MV) ? (lim / TEN_MV) * TEN_MV : lim;  // floor keeps 3 digits inside limit
            end
            biasLevelNext = cmdReg.num[NUM_W-1] ? -BIAS_W'(mag) : BIAS_W'(mag);
          end
        end
        OP_BIAS_LEVEL_QRY: begin
          if (isDc) begin
            errNow       = 1'b1;
            rspNext      = '0;
            rspNext.valid = 1'b1;
            rspNext.kind = RSP_OVERFLOW;
          end else begin
            errNow  = !biasEnable;
            rspNext = biasRsp(biasLevel);
          end
        end
        OP_FRAC_ENABLE_SET: begin
          if (switchOn && !canRatio) begin
            errNow = 1'b1;
          end else begin
            fracEnableNext = switchOn;
          end
        end
        OP_FRAC_ENABLE_QRY: begin
          errNow  = !canRatio;
          rspNext = numRsp({{(MANT_W-1){1'b0}}, onFractionEnable && canRatio}, PT_NONE, EXP_UNIT);
        end
        OP_FRAC_LEVEL_SET: begin
          if (!canRatio) begin
            errNow = 1'b1;
          end else if (!onFractionEnable) begin
            errNow = 1'b1;
          end else if (cmdReg.num[NUM_W-1]) begin
            errNow = 1'b1;
          end else begin
            mag = (NUM_W'(cmdReg.num) + RATIO_HALF) / RATIO_DIV;
            if (mag < NUM_W'(ratioMin)) begin
              errNow = 1'b1;
              mag    = NUM_W'(ratioMin);
            end else if (mag > NUM_W'(ratioMax)) begin
              errNow = 1'b1;
              mag    = NUM_W'(ratioMax);
            end
            memWe    = 1'b1;
            memWdata = mag[RATIO_W-1:0];
          end
        end
        OP_FRAC_LEVEL_QRY: begin
          if (!canRatio) begin
            errNow  = 1'b1;
            rspNext = numRsp(RATIO_NONE, PT_TENTHS, EXP_UNIT);
          end else begin
            errNow  = !onFractionEnable;
            rspNext = numRsp(MANT_W'(memRatio), PT_TENTHS, EXP_UNIT);
          end
        end
        OP_EMIT_SET: emitEnableNext = switchOn;
        OP_EMIT_QRY: rspNext = numRsp({{(MANT_W-1){1'b0}}, emitEnable}, PT_NONE, EXP_UNIT);
        OP_WAVE_QRY: begin
          rspNext       = '0;
          rspNext.valid = 1'b1;
          rspNext.kind  = RSP_WAVE;
          rspNext.wave  = waveReg;
        end
        default: errNow = 1'b0;  // unknown codes do nothing
      endcase
    end
  end

  // sequencer and command latch
  always_ff @(posedge core_clk) begin
    if (rst) begin
      stateReg <= ST_IDLE;
      cmdReg   <= '0;
    end else begin
      stateReg <= stateNext;
      if (cmdIn.valid && cmdReady) begin
        cmdReg <= cmdIn;
      end
    end
  end

  // waveform tracking
  always_ff @(posedge core_clk) begin
    if (rst) begin
      waveReg    <= WAVE_SINUSOID;
      dcForceOff <= 1'b0;
    end else begin
      waveReg    <= waveSel;
      dcForceOff <= waveChange && (waveSel == WAVE_DC);
    end
  end

  // settings; a switch to DC or to an unfit waveform overrides an offset or on-fraction enable command in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      biasEnable       <= 1'b0;
      biasLevel        <= BIAS_RST;
      onFractionEnable <= 1'b0;
      emitEnable       <= 1'b0;
    end else begin
      biasEnable       <= biasEnableNext && !(waveChange && (waveSel == WAVE_DC));
      biasLevel        <= biasLevelNext;
      onFractionEnable <= fracEnableNext && !(waveChange && !waveCanRatio(waveSel));
      emitEnable       <= emitEnableNext;
    end
  end

  // reply register
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rspOut <= '0;
    end else begin
      rspOut <= rspNext;
    end
  end

  // sticky error; a new error wins over a clear in the same cycle
  always_ff @(posedge core_clk) begin
    if (rst) begin
      execErrFlag  <= 1'b0;
      execErrPulse <= 1'b0;
    end else begin
      execErrPulse <= errNow;
      if (errNow) begin
        execErrFlag <= 1'b1;
      end else if (execErrClear) begin
        execErrFlag <= 1'b0;
      end
    end
  end

  // per-waveform ratio store; the live ratio follows the waveform
  ods_ratio_mem u_ratio_mem (
    .core_clk  (core_clk),
    .rst       (rst),
    .writeEn   (memWe),
    .writeAddr (waveReg),
    .writeData (memWdata),
    .readAddr  (waveReg),
    .readData  (memRatio)
  );

  assign onFractionLevel = memRatio;

endmodule : ods_settings

// ---- tb/ods_host_model.sv ----
`timescale 1ns/1ns
// remote host side: sends one parsed command at a time and keeps its reply
module ods_host_model (
  // clock
  input  wire logic              core_clk,
  // command out, reply in
  output      ods_pkg::ods_cmd_t cmdIn,
  input  wire logic              cmdReady,
  input  wire ods_pkg::ods_rsp_t rspOut,
  input  wire logic              execErrPulse
);
  import ods_pkg::*;

  ods_rsp_t rsp;  // reply seen in the cycle after the execute cycle
  logic     err;  // error pulse seen with it
  logic     hung; // request never taken within the bound

  initial begin
    cmdIn = '0;
    hung  = 1'h0;
  end

  // request held until taken; payload then inverted, so nothing stale looks valid
  task automatic send(input ods_op_t op, input logic w, input logic on, input logic [NUM_W-1:0] n);
    int i;
    @(posedge core_clk);
    cmdIn <= '{valid: 1'h1, op: op, isWord: w, wordOn: on, num: n};
    @(negedge core_clk);
    for (i = 0; i < 16 && cmdReady !== 1'h1; i++) begin
      @(negedge core_clk);
    end
    hung = (cmdReady !== 1'h1);
    @(posedge core_clk);
    cmdIn <= {1'h0, ~cmdIn[$bits(ods_cmd_t)-2:0]};
    // reply and error pulse are registered at the edge that ends the execute cycle
    @(posedge core_clk);
    @(negedge core_clk);
    rsp = rspOut;
    err = execErrPulse;
  endtask : send
endmodule : ods_host_model

// ---- tb/ods_settings_asserts.sv ----
`timescale 1ns/1ns
// timing and side-effect checks at the settings block ports
module ods_settings_asserts (
  // clock and reset
  input wire logic                              core_clk,
  input wire logic                              rst,
  // command and reply
  input wire ods_pkg::ods_cmd_t                 cmdIn,
  input wire logic                              cmdReady,
  input wire ods_pkg::ods_rsp_t                 rspOut,
  // context and settings
  input wire ods_pkg::ods_wave_t                waveSel,
  input wire logic                              biasEnable,
  input wire logic signed [ods_pkg::BIAS_W-1:0] biasLevel,
  input wire logic                              onFractionEnable,
  input wire logic                              dcForceOff,
  // error flag
  input wire logic                              execErrClear,
  input wire logic                              execErrFlag,
  input wire logic                              execErrPulse
);
  import ods_pkg::*;

  logic takeNow; // command accepted at this edge
  assign takeNow = cmdIn.valid && cmdReady;

  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);

  // waveform held at DC for a few cycles, long enough for forced-off to land
  sequence dcHeld_s;
    (waveSel == WAVE_DC) [*4];
  endsequence
  // waveform that cannot use the on fraction, held
  sequence unfitHeld_s;
    (waveSel inside {WAVE_SINUSOID, WAVE_TRIANGLE, WAVE_DC}) [*4];
  endsequence
  // flag cleared with no new error in the next cycle
  sequence clearQuiet_s;
    execErrFlag && execErrClear ##1 !execErrPulse;
  endsequence

  busy_after_take_a: assert property (takeNow |=> !cmdReady)
    else $error("ready high in execute cycle");
  reply_timing_a: assert property (rspOut.valid |-> $past(takeNow, 2))
    else $error("reply without a take two cycles before");
  reply_pulse_a: assert property (rspOut.valid |=> !rspOut.valid)
    else $error("reply valid longer than one cycle");
  dc_bias_off_a: assert property (dcHeld_s |-> !biasEnable)
    else $error("offset enabled during DC");
  dc_level_hold_a: assert property ((waveSel == WAVE_DC) [*3] |-> $stable(biasLevel))
    else $error("offset level changed during DC");
  dc_force_cause_a: assert property ($changed(waveSel) && waveSel == WAVE_DC |-> ##[1:2] dcForceOff)
    else $error("no forced-off pulse on DC switch");
  unfit_frac_off_a: assert property (unfitHeld_s |-> !onFractionEnable)
    else $error("on fraction enabled on unfit waveform");
  err_set_a: assert property (execErrPulse |-> execErrFlag)
    else $error("error pulse without sticky flag");
  err_hold_a: assert property (execErrFlag && !execErrClear |=> execErrFlag)
    else $error("sticky flag dropped without clear");
  err_clear_a: assert property (clearQuiet_s |-> !execErrFlag)
    else $error("sticky flag not cleared");
  err_cause_a: assert property (execErrPulse |-> $past(takeNow, 2))
    else $error("error pulse without a command");
endmodule : ods_settings_asserts

bind ods_settings ods_settings_asserts u_chk (
  .core_clk(core_clk), .rst(rst), .cmdIn(cmdIn), .cmdReady(cmdReady), .rspOut(rspOut),
  .waveSel(waveSel), .biasEnable(biasEnable), .biasLevel(biasLevel),
  .onFractionEnable(onFractionEnable), .dcForceOff(dcForceOff),
  .execErrClear(execErrClear), .execErrFlag(execErrFlag), .execErrPulse(execErrPulse)
);

// ---- tb/ods_settings_tb.sv ----
`timescale 1ns/1ns
module ods_settings_tb;
  import ods_pkg::*;

  // clock and reset
  logic                     core_clk;
  logic                     rst;
  // command and reply
  ods_cmd_t                 cmdIn;
  logic                     cmdReady;
  ods_rsp_t                 rspOut;
  // context
  ods_wave_t                waveSel;
  logic [AMP_W-1:0]         ampMv;
  logic [RATIO_W-1:0]       ratioMin;
  logic [RATIO_W-1:0]       ratioMax;
  // settings and error
  logic                     biasEnable;
  logic signed [BIAS_W-1:0] biasLevel;
  logic                     onFractionEnable;
  logic [RATIO_W-1:0]       onFractionLevel;
  logic                     emitEnable;
  logic                     dcForceOff;
  logic                     execErrClear;
  logic                     execErrFlag;
  logic                     execErrPulse;
  int                       fails;
  int                       comparisons;

  ods_settings u_dut (
    .core_clk(core_clk), .rst(rst), .cmdIn(cmdIn), .cmdReady(cmdReady), .rspOut(rspOut),
    .waveSel(waveSel), .ampMv(ampMv), .ratioMin(ratioMin), .ratioMax(ratioMax),
    .biasEnable(biasEnable), .biasLevel(biasLevel), .onFractionEnable(onFractionEnable),
    .onFractionLevel(onFractionLevel), .emitEnable(emitEnable), .dcForceOff(dcForceOff),
    .execErrClear(execErrClear), .execErrFlag(execErrFlag), .execErrPulse(execErrPulse)
  );

  ods_host_model u_host (
    .core_clk(core_clk), .cmdIn(cmdIn), .cmdReady(cmdReady), .rspOut(rspOut), .execErrPulse(execErrPulse)
  );

  // 125 MHz
  initial core_clk = 1'h0;
  always #4 core_clk = ~core_clk;

  // verdict and end of run
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : report_and_stop

  // case equality, so an unknown never matches
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      fails++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // one command, then its error pulse
  task automatic c(input ods_op_t op, input logic w, input logic on, input logic [31:0] n, input logic e);
    u_host.send(op, w, on, n);
    if (u_host.hung) begin
      fails++;
      report_and_stop();
    end
    chk("execErrPulse", e, u_host.err);
  endtask : c

  // one query, then reply kind and mantissa
  task automatic q(input ods_op_t op, input logic e, input logic [17:0] km);
    c(op, 1'h0, 1'h0, 32'h0, e);
    chk("reply", {1'h1, km}, {u_host.rsp.valid, u_host.rsp.kind, u_host.rsp.mant});
  endtask : q

  // waveform change; hold long enough for forced-off effects
  task automatic setWave(input ods_wave_t w);
    @(posedge core_clk);
    waveSel <= w;
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
  endtask : setWave

  // hang guard: bounded well inside the run limit
  initial begin
    repeat (20000) @(posedge core_clk);
    fails++;
    report_and_stop();
  end

  initial begin
    fails = 0;
    comparisons = 0;
    rst = 1'h1;
    waveSel = WAVE_SINUSOID;
    ampMv = 14'h03E8;
    ratioMin = 10'h00A;
    ratioMax = 10'h3DE;
    execErrClear = 1'h0;
    repeat (2) @(posedge core_clk);
    rst <= 1'h0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk("reset", {4'h0, BIAS_RST, RATIO_RST},
        {biasEnable, onFractionEnable, emitEnable, execErrFlag, biasLevel, onFractionLevel});
    $display("test reset done");
    // output switch: word and rounded-number forms
    c(OP_EMIT_SET, 1'h1, 1'h1, 32'h0, 1'h0);
    q(OP_EMIT_QRY, 1'h0, {RSP_NUMBER, 16'h0001});
    c(OP_EMIT_SET, 1'h0, 1'h0, 32'h0000_0190, 1'h0);
    chk("emitEnable", 1'h0, emitEnable);
    c(OP_EMIT_SET, 1'h0, 1'h0, 32'h0000_0258, 1'h0);
    chk("emitEnable", 1'h1, emitEnable);
    c(OP_EMIT_SET, 1'h1, 1'h0, 32'h0000_03E8, 1'h0);
    q(OP_EMIT_QRY, 1'h0, {RSP_NUMBER, 16'h0000});
    $display("test output switch done");
    // offset level: refused while off, rounding, reply format, clamp
    setWave(WAVE_RECTANGULAR);
    c(OP_BIAS_LEVEL_SET, 1'h0, 1'h0, 32'h0012_D687, 1'h1);
    q(OP_BIAS_LEVEL_QRY, 1'h1, {RSP_NUMBER, 16'h0000});
    c(OP_BIAS_ENABLE_SET, 1'h0, 1'h0, 32'h0000_03E8, 1'h0);
    q(OP_BIAS_ENABLE_QRY, 1'h0, {RSP_NUMBER, 16'h0001});
    c(OP_BIAS_LEVEL_SET, 1'h0, 1'h0, 32'h0012_D687, 1'h0);
    q(OP_BIAS_LEVEL_QRY, 1'h0, {RSP_NUMBER, 16'h007B});
    chk("format", {PT_HUNDRED, EXP_UNIT}, {u_host.rsp.point, u_host.rsp.exp});
    c(OP_BIAS_LEVEL_SET, 1'h0, 1'h0, 32'hFFF8_5D50, 1'h0);
    q(OP_BIAS_LEVEL_QRY, 1'h0, {RSP_NUMBER, 16'hFE0C});
    chk("format", {PT_NONE, EXP_MILLI}, {u_host.rsp.point, u_host.rsp.exp});
    c(OP_BIAS_LEVEL_SET, 1'h0, 1'h0, 32'h005B_8D80, 1'h1);
    chk("biasLevel", 16'h11A8, biasLevel);
    chk("execErrFlag", 1'h1, execErrFlag);
    @(posedge core_clk);
    execErrClear <= 1'h1;
    @(posedge core_clk);
    execErrClear <= 1'h0;
    @(negedge core_clk);
    chk("execErrFlag", 1'h0, execErrFlag);
    $display("test offset done");
    // DC: offset forced off and every offset request except switching the offset off refused
    setWave(WAVE_DC);
    chk("biasEnable", 1'h0, biasEnable);
    c(OP_BIAS_ENABLE_SET, 1'h1, 1'h1, 32'h0, 1'h1);
    chk("biasEnable", 1'h0, biasEnable);
    q(OP_BIAS_ENABLE_QRY, 1'h1, {RSP_NUMBER, 16'h0000});
    c(OP_BIAS_LEVEL_SET, 1'h0, 1'h0, 32'h0, 1'h1);
    chk("biasLevel", 16'h11A8, biasLevel);
    q(OP_BIAS_LEVEL_QRY, 1'h1, {RSP_OVERFLOW, 16'h0000});
    $display("test dc done");
    // on fraction: unfit waveform, switch off, rounding, negative, clamp
    setWave(WAVE_SINUSOID);
    c(OP_FRAC_ENABLE_SET, 1'h1, 1'h1, 32'h0, 1'h1);
    chk("onFractionEnable", 1'h0, onFractionEnable);
    q(OP_FRAC_ENABLE_QRY, 1'h1, {RSP_NUMBER, 16'h0000});
    c(OP_FRAC_LEVEL_SET, 1'h0, 1'h0, 32'h0000_09E8, 1'h1);
    q(OP_FRAC_LEVEL_QRY, 1'h1, {RSP_NUMBER, RATIO_NONE});
    setWave(WAVE_RECTANGULAR);
    c(OP_FRAC_LEVEL_SET, 1'h0, 1'h0, 32'h0000_09E8, 1'h1);
    c(OP_FRAC_ENABLE_SET, 1'h1, 1'h1, 32'h0, 1'h0);
    q(OP_FRAC_LEVEL_QRY, 1'h0, {RSP_NUMBER, 16'h01F4});
    c(OP_FRAC_LEVEL_SET, 1'h0, 1'h0, 32'h0000_09E8, 1'h0);
    q(OP_FRAC_LEVEL_QRY, 1'h0, {RSP_NUMBER, 16'h00FE});
    chk("point", PT_TENTHS, u_host.rsp.point);
    c(OP_FRAC_LEVEL_SET, 1'h0, 1'h0, 32'hFFFF_FF9C, 1'h1);
    q(OP_FRAC_LEVEL_QRY, 1'h0, {RSP_NUMBER, 16'h00FE});
    c(OP_FRAC_LEVEL_SET, 1'h0, 1'h0, 32'h0001_863C, 1'h1);
    setWave(WAVE_RAMP);
    chk("onFractionLevel", RATIO_RST, onFractionLevel);
    setWave(WAVE_RECTANGULAR);
    chk("onFractionLevel", 10'h3DE, onFractionLevel);
    setWave(WAVE_TRIANGLE);
    chk("onFractionEnable", 1'h0, onFractionEnable);
    setWave(WAVE_RECTANGULAR);
    q(OP_FRAC_LEVEL_QRY, 1'h1, {RSP_NUMBER, 16'h03DE});
    $display("test on fraction done");
    // waveform query for every type
    for (int i = 0; i < NUM_WAVES; i++) begin
      setWave(ods_wave_t'(i));
      c(OP_WAVE_QRY, 1'h0, 1'h0, 32'h0, 1'h0);
      chk("wave", {1'h1, RSP_WAVE, ods_wave_t'(i)}, {u_host.rsp.valid, u_host.rsp.kind, u_host.rsp.wave});
    end
    $display("test waveform query done");
    report_and_stop();
  end
endmodule : ods_settings_tb
